// ==== shared/cmc_pkg.sv ====
// cmc_pkg: constants, states and pin carrier for the card mode control block
// assumes a single 10 MHz core clock; all times are converted here
package cmc_pkg;

  // core clock rate and synchroniser depth
  localparam int CLK_HZ = 10_000_000;
  localparam int SYNC_STAGES = 3;

  // cycles allowed for pin synchronisers to settle before strapping
  localparam int STRAP_CYC = 4;
  // strap is taken on the last count, once the pin filter has settled
  localparam logic [2:0] STRAP_LAST = 3'(STRAP_CYC);

  // status change pulse: least low time, rounded up to whole cycles
  localparam int STS_PULSE_NS = 1000;
  localparam int STS_PULSE_CYC_I =
    (STS_PULSE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam logic [3:0] STS_PULSE_CYC = 4'(STS_PULSE_CYC_I);

  // value of every filtered pin while reset is applied (idle levels)
  localparam logic [7:0] PIN_RST = 8'hFF;

  // sequence state, one-hot
  typedef enum logic [3:0] {
    ST_STRAP = 4'h1,
    ST_INIT  = 4'h2,
    ST_HOLD  = 4'h4,
    ST_RUN   = 4'h8
  } cmc_state_t;

  // host-side control pins after synchronising and filtering
  typedef struct packed {
    logic oe_n;     // output enable strap, low selects ide mode
    logic csel_n;   // cable select, low = master
    logic reg_n;    // attribute space select
    logic ce1_n;    // card enable, even byte
    logic ce2_n;    // card enable, odd byte
    logic iord_n;   // i/o read strobe
    logic rst_lvl;  // reset pin level, meaning depends on mode
    logic pdiag_n;  // pass diagnostic line level
  } cmc_pins_t;

endpackage : cmc_pkg

// ==== hw/cmc_sync.sv ====
// cmc_sync: three-stage synchroniser bank for asynchronous pins
// assumes reset already synchronised to clk_in; exposes stages two and three
`timescale 1ns/10ps
module cmc_sync #(
  parameter int WIDTH = 8,
  parameter logic [WIDTH-1:0] RST_VAL = '1
) (
  input wire logic clk_in,              // core clock
  input wire logic rst_n_in,            // synchronised reset, active low
  input wire logic [WIDTH-1:0] d_in,    // raw pin levels
  output logic [WIDTH-1:0] s2_out,      // second stage
  output logic [WIDTH-1:0] s3_out       // third stage
);

  // refuse a degenerate bank
  if (WIDTH < 1) begin : g_chk
    $error("cmc_sync: WIDTH must be at least 1");
  end

  // one three-flop chain per bit; first stage feeds only the second
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    logic s1_r;
    logic s2_r;
    logic s3_r;
    always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
        s1_r <= RST_VAL[i];
        s2_r <= RST_VAL[i];
        s3_r <= RST_VAL[i];
      end else begin
        s1_r <= d_in[i];
        s2_r <= s1_r;
        s3_r <= s2_r;
      end
    end
    assign s2_out[i] = s2_r;
    assign s3_out[i] = s3_r;
  end

endmodule : cmc_sync

// ==== hw/cmc_ctrl.sv ====
// cmc_ctrl: mode-dependent control and status pins of the card interface
// assumes host pins are asynchronous; config and init inputs share mclk_in
`timescale 1ns/10ps
module cmc_ctrl
  import cmc_pkg::*;
(
  input wire logic mclk_in,         // 10 MHz core clock
  input wire logic resetn_in,       // power-up reset, active low, async
  input wire logic oe_n_in,         // output enable pin, strap
  input wire logic csel_n_in,       // cable select pin
  input wire logic reg_n_in,        // attribute select pin
  input wire logic ce1_n_in,        // card enable 1 pin
  input wire logic ce2_n_in,        // card enable 2 pin
  input wire logic iord_n_in,       // i/o read pin
  input wire logic rst_pin_in,      // reset pin level
  input wire logic pin63_in,        // level seen on shared status pin
  input wire logic io_cfg_in,       // card configured for i/o interface
  input wire logic soft_reset_in,   // soft reset bit from option register
  input wire logic stschg_en_in,    // status change enable from status reg
  input wire logic init_done_in,    // internal initialization finished
  input wire logic rdy_in,          // internal ready state
  input wire logic wp_state_in,     // internal write protect state
  input wire logic addr_hit_in,     // address decodes to a card port
  input wire logic port16_in,       // addressed port accepts 16 bits
  input wire logic pdiag_assert_in, // drive pass diagnostic asserted
  output logic ide_mode_out,        // ide mode strapped
  output logic master_out,          // ide master role
  output logic attr_sel_out,        // attribute space access
  output logic common_sel_out,      // common memory access
  output logic wp_iois16_out,       // write protect / 16-bit indication
  output logic inpack_n_out,        // input acknowledge, active low
  output logic pin63_out,           // shared status pin drive level
  output logic pin63_oe_n_out,      // shared status pin enable, low drives
  output logic pdiag_seen_out,      // partner asserting pass diagnostic
  output logic wait_out,            // wait/ready drive level
  output logic wait_oe_n_out,       // wait/ready enable, low drives
  output logic rdy_bsy_out,         // ready/busy, low while busy
  output logic card_rst_out         // reset to the rest of the card
);

  // reset release through two flops
  logic [1:0] rsync_r;
  logic rst_n;
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) rsync_r <= 2'h0;
    else rsync_r <= {rsync_r[0], 1'b1};
  end
  assign rst_n = rsync_r[1];

  // pin synchronisers and agreement filter
  cmc_pins_t pin_raw, pin_r, pin_nxt;
  logic [7:0] s2, s3;
  assign pin_raw = '{oe_n: oe_n_in, csel_n: csel_n_in, reg_n: reg_n_in,
                     ce1_n: ce1_n_in, ce2_n: ce2_n_in, iord_n: iord_n_in,
                     rst_lvl: rst_pin_in, pdiag_n: pin63_in};
  cmc_sync #(.WIDTH(8), .RST_VAL(PIN_RST)) u_sync (
    .clk_in(mclk_in),
    .rst_n_in(rst_n),
    .d_in(pin_raw),
    .s2_out(s2),
    .s3_out(s3)
  );
  always_comb begin
    pin_nxt = (s2 & s3) | (pin_r & (s2 ^ s3));
  end
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) pin_r <= PIN_RST;
    else pin_r <= pin_nxt;
  end

  // sequence state: strap, init, pin reset hold, run
  cmc_state_t st_r, st_nxt;
  logic [2:0] cnt_r, cnt_nxt;
  logic ide_r, ide_nxt, master_r, master_nxt, armed_r, armed_nxt;
  logic crst_nxt, hw_rst;
  // pc modes: high resets only once the pin was seen low, ide: active low
  assign hw_rst = ide_r ? !pin_r.rst_lvl
                        : (pin_r.rst_lvl && armed_r);
  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    ide_nxt = ide_r;
    master_nxt = master_r;
    armed_nxt = armed_r;
    if (st_r != ST_STRAP && !ide_r && !pin_r.rst_lvl) armed_nxt = 1'b1;
    case (st_r)
      ST_STRAP: begin
        cnt_nxt = cnt_r + 3'h1;
        if (cnt_r == STRAP_LAST) begin
          cnt_nxt = 3'h0;
          ide_nxt = !pin_r.oe_n;
          master_nxt = !pin_r.oe_n && !pin_r.csel_n;
          st_nxt = ST_INIT;
        end
      end
      ST_INIT: begin
        if (hw_rst) st_nxt = ST_HOLD;
        else if (init_done_in) st_nxt = ST_RUN;
      end
      ST_HOLD: begin
        if (!hw_rst) st_nxt = ST_STRAP;
      end
      ST_RUN: begin
        if (hw_rst) st_nxt = ST_HOLD;
        else if (soft_reset_in) st_nxt = ST_INIT;
      end
      default: st_nxt = ST_STRAP;
    endcase
    crst_nxt = (st_nxt == ST_STRAP) || (st_nxt == ST_HOLD) ||
               (st_r == ST_RUN && st_nxt == ST_INIT);
  end
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= ST_STRAP;
      cnt_r <= 3'h0;
      ide_r <= 1'b0;
      master_r <= 1'b0;
      armed_r <= 1'b0;
      card_rst_out <= 1'b1;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      ide_r <= ide_nxt;
      master_r <= master_nxt;
      armed_r <= armed_nxt;
      card_rst_out <= crst_nxt;
    end
  end

  // status change detector and pulse timer
  logic run, mem, io, sel, sts_chg;
  logic [1:0] prev_r, prev_nxt;
  logic [3:0] pcnt_r, pcnt_nxt;
  assign run = (st_r == ST_RUN);
  assign mem = !ide_r && !io_cfg_in && st_r != ST_STRAP;
  assign io = !ide_r && io_cfg_in && run;
  assign sel = !pin_r.ce1_n || !pin_r.ce2_n;
  assign sts_chg = io && stschg_en_in && (prev_r != {rdy_in, wp_state_in});
  always_comb begin
    prev_nxt = {rdy_in, wp_state_in};
    if (sts_chg) pcnt_nxt = STS_PULSE_CYC;
    else if (pcnt_r != 4'h0) pcnt_nxt = pcnt_r - 4'h1;
    else pcnt_nxt = pcnt_r;
  end
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      prev_r <= 2'h0;
      pcnt_r <= 4'h0;
    end else begin
      prev_r <= prev_nxt;
      pcnt_r <= pcnt_nxt;
    end
  end

  // registered pin outputs per mode
  logic attr_nxt, common_nxt, wpio_nxt, inpack_nxt, p63_nxt, p63oe_nxt;
  logic pdseen_nxt, rdy_nxt;
  always_comb begin
    // -REG ignored in ide mode, routes space in memory mode
    attr_nxt = mem && run && sel && !pin_r.reg_n;
    common_nxt = mem && run && sel && pin_r.reg_n;
    // host holds -REG low in i/o cycles; acknowledge only a decoded read
    inpack_nxt = !(io && sel && !pin_r.reg_n && !pin_r.iord_n &&
                   addr_hit_in);
    rdy_nxt = run && rdy_in;
    pdseen_nxt = ide_r && !pin_r.pdiag_n;
    wpio_nxt = 1'b1;
    p63_nxt = 1'b1;
    p63oe_nxt = 1'b1;
    if (st_r == ST_STRAP) begin
      p63oe_nxt = 1'b1;
    end else if (ide_r) begin
      p63_nxt = 1'b0;
      p63oe_nxt = !pdiag_assert_in;
    end else if (io_cfg_in) begin
      wpio_nxt = !(run && port16_in && addr_hit_in);
      p63_nxt = (pcnt_r == 4'h0);
      p63oe_nxt = 1'b0;
    end else begin
      wpio_nxt = !run;
      p63_nxt = 1'b1;
      p63oe_nxt = 1'b0;
    end
  end
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      attr_sel_out <= 1'b0;
      common_sel_out <= 1'b0;
      wp_iois16_out <= 1'b1;
      inpack_n_out <= 1'b1;
      pin63_out <= 1'b1;
      pin63_oe_n_out <= 1'b1;
      pdiag_seen_out <= 1'b0;
      rdy_bsy_out <= 1'b0;
    end else begin
      attr_sel_out <= attr_nxt;
      common_sel_out <= common_nxt;
      wp_iois16_out <= wpio_nxt;
      inpack_n_out <= inpack_nxt;
      pin63_out <= p63_nxt;
      pin63_oe_n_out <= p63oe_nxt;
      pdiag_seen_out <= pdseen_nxt;
      rdy_bsy_out <= rdy_nxt;
    end
  end

  // strap results and the never-driven wait line
  assign ide_mode_out = ide_r;
  assign master_out = master_r;
  assign wait_out = 1'b1;
  assign wait_oe_n_out = 1'b1;

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n);

  AST_STRAP: assert property (
    (st_r == ST_STRAP && cnt_r == STRAP_LAST) |=>
    ide_r == !$past(pin_r.oe_n) && st_r == ST_INIT)
    else $error("mode strap not latched at end of strap window");
  AST_MASTER: assert property ($rose(st_r == ST_INIT) && ide_r |->
    master_out == !$past(pin_r.csel_n))
    else $error("master role does not follow cable select");
  AST_ATTR: assert property ((mem && run && sel && !pin_r.reg_n) |=>
    attr_sel_out && !common_sel_out)
    else $error("attribute access not routed");
  AST_WP: assert property ((mem && !io_cfg_in && $past(mem)) |->
    wp_iois16_out == !$past(run))
    else $error("write protect level wrong around init");
  AST_INPACK: assert property (!inpack_n_out |-> $past(io && sel &&
    !pin_r.iord_n && addr_hit_in))
    else $error("input acknowledge without a decoded i/o read");
  AST_BVD: assert property (
    (mem && !ide_r) ##1 (!io_cfg_in && mem) |->
    pin63_out && !pin63_oe_n_out)
    else $error("battery status not held high");
  // timer loads one edge after the change, pin follows one edge later
  AST_STSCHG: assert property (
    sts_chg |-> ##2 !pin63_out [*5] ##1 !pin63_out [*5])
    else $error("status change pulse too short");
  AST_NOWAIT: assert property (wait_oe_n_out && wait_out)
    else $error("wait line driven");
  AST_PCRST: assert property (
    (run && !ide_r && armed_r && pin_r.rst_lvl)
    |=> st_r == ST_HOLD ##1 card_rst_out)
    else $error("reset pin high did not reset card");
  AST_ONCE: assert property ((!ide_r && !armed_r && st_r != ST_STRAP)
    |=> st_r != ST_HOLD)
    else $error("reset repeated with pin held high from power-up");
  AST_SOFT: assert property ((run && !hw_rst && soft_reset_in) |=>
    st_r == ST_INIT && card_rst_out)
    else $error("soft reset ignored");
  AST_BUSY: assert property ((st_r != ST_RUN) |=> !rdy_bsy_out)
    else $error("ready shown before init complete");

endmodule : cmc_ctrl

// ==== tb/cmc_host.sv ====
// cmc_host: behavioural host socket facing the card control pins
// assumes the bench calls its tasks shortly after a clock edge
`timescale 1ns/10ps
module cmc_host (
  input wire logic pin63_drv_in,  // card drive level on pin 63
  input wire logic pin63_oe_n_in, // card enable on pin 63, low drives
  input wire logic inpack_n_in,   // card input acknowledge
  output logic oe_n_out,          // output enable pin, mode strap
  output logic csel_n_out,        // cable select as the card sees it
  output logic reg_n_out,         // attribute select pin
  output logic ce1_n_out,         // card enable 1
  output logic ce2_n_out,         // card enable 2
  output logic iord_n_out,        // i/o read strobe
  output logic pin63_out,         // resolved level of pin 63
  output logic buf_en_out         // host input buffer enable
);
  logic csel_gnd = 1'b0;
  logic pd_pull = 1'b0;
  // open cable select reads high through the card pull-up
  assign csel_n_out = ~csel_gnd;
  // pin 63 is wired-and with a pull-up, so a released line reads high
  assign pin63_out = (pin63_oe_n_in | pin63_drv_in) & ~pd_pull;
  // buffers toward the host cpu open only on acknowledge
  assign buf_en_out = ~inpack_n_in;
  // idle pins from time zero
  initial begin
    oe_n_out = 1'b1;
    ce1_n_out = 1'b1;
    ce2_n_out = 1'b1;
    reg_n_out = 1'b1;
    iord_n_out = 1'b1;
  end
  // grounding output enable picks ide mode
  task automatic strap(input logic ide);
    oe_n_out = ~ide;
  endtask : strap
  task automatic set_csel(input logic gnd);
    csel_gnd = gnd;
  endtask : set_csel
  // pull the pass diagnostic line low as the other drive would
  task automatic set_pd(input logic pull);
    pd_pull = pull;
  endtask : set_pd
  // attribute select is kept low for the whole i/o read strobe
  task automatic drive(input logic ce, input logic rg, input logic rd);
    ce1_n_out = ce;
    ce2_n_out = ce;
    iord_n_out = rd;
    reg_n_out = rg & rd;
  endtask : drive
endmodule : cmc_host

// ==== tb/testbench.sv ====
// testbench: runs the card control block through memory, i/o and ide modes
// assumes cmc_pkg, cmc_ctrl and cmc_host are compiled first; 10 MHz clock
`timescale 1ns/10ps
module testbench;
  import cmc_pkg::*;
  localparam int I_IDE = 0, I_MST = 1, I_ATTR = 2, I_COM = 3, I_WP = 4;
  localparam int I_INP = 5, I_P63 = 6, I_P63OE = 7, I_SEEN = 8;
  localparam int I_RDY = 9, I_RST = 10;
  logic mclk_in = 1'b0, resetn_in = 1'b0, rst_pin_in = 1'b1;
  logic io_cfg_in = 1'b0, soft_reset_in = 1'b0, stschg_en_in = 1'b0;
  logic init_done_in = 1'b0, rdy_in = 1'b1, wp_state_in = 1'b0;
  logic addr_hit_in = 1'b1, port16_in = 1'b1, pdiag_assert_in = 1'b0;
  logic oe_n, csel_n, reg_n, ce1_n, ce2_n, iord_n, p63_wire, buf_en;
  logic ide, mst, attr, com, wp, inp_n, p63, p63oe_n, seen, wt, wt_oe_n;
  logic rdy_bsy, crst;
  logic [10:0] obs;
  int fails = 0, checks_done = 0;
  assign obs = {crst, rdy_bsy, seen, p63oe_n, p63, inp_n, wp, com, attr,
                mst, ide};
  // free-running core clock
  always #50 mclk_in = ~mclk_in;
  cmc_host host (.pin63_drv_in(p63), .pin63_oe_n_in(p63oe_n),
    .inpack_n_in(inp_n), .oe_n_out(oe_n), .csel_n_out(csel_n),
    .reg_n_out(reg_n), .ce1_n_out(ce1_n), .ce2_n_out(ce2_n),
    .iord_n_out(iord_n), .pin63_out(p63_wire), .buf_en_out(buf_en));
  cmc_ctrl dut (.mclk_in(mclk_in), .resetn_in(resetn_in), .oe_n_in(oe_n),
    .csel_n_in(csel_n), .reg_n_in(reg_n), .ce1_n_in(ce1_n),
    .ce2_n_in(ce2_n), .iord_n_in(iord_n), .rst_pin_in(rst_pin_in),
    .pin63_in(p63_wire), .io_cfg_in(io_cfg_in),
    .soft_reset_in(soft_reset_in), .stschg_en_in(stschg_en_in),
    .init_done_in(init_done_in), .rdy_in(rdy_in), .wp_state_in(wp_state_in),
    .addr_hit_in(addr_hit_in), .port16_in(port16_in),
    .pdiag_assert_in(pdiag_assert_in), .ide_mode_out(ide), .master_out(mst),
    .attr_sel_out(attr), .common_sel_out(com), .wp_iois16_out(wp),
    .inpack_n_out(inp_n), .pin63_out(p63), .pin63_oe_n_out(p63oe_n),
    .pdiag_seen_out(seen), .wait_out(wt), .wait_oe_n_out(wt_oe_n),
    .rdy_bsy_out(rdy_bsy), .card_rst_out(crst));
  task automatic summarize;
    $display("checks_done=%0d fails=%0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : summarize
  // inputs change a fixed 5 ns after the rising edge
  task automatic tick(input int n = 1);
    repeat (n) @(posedge mclk_in);
    #5;
  endtask : tick
  task automatic check(input logic seen_v, input logic exp_v);
    checks_done++;
    if (seen_v !== exp_v) begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen_v, exp_v);
    end
  endtask : check
  // bounded wait for an output level; running out ends the run
  task automatic await(input int idx, input logic v, input int n);
    int k;
    k = 0;
    while (obs[idx] !== v && k < n) begin
      tick();
      k++;
    end
    check(obs[idx], v);
    if (obs[idx] !== v) summarize();
  endtask : await
  // an output must keep its level for n cycles
  task automatic hold(input int idx, input logic v, input int n);
    logic ok;
    ok = 1'b1;
    repeat (n) begin
      tick();
      if (obs[idx] !== v) ok = 1'b0;
    end
    check(ok, 1'b1);
  endtask : hold
  // power-up reset with straps settled well before release
  task automatic boot(input logic ide_v);
    resetn_in = 1'b0;
    rst_pin_in = 1'b1;
    host.strap(ide_v);
    tick(20);
    resetn_in = 1'b1;
  endtask : boot
  task automatic test_mem;
    boot(1'b0);
    host.set_csel(1'b1);
    await(I_RST, 1'b0, 12);
    hold(I_RST, 1'b0, 15);
    hold(I_RDY, 1'b0, 10);
    init_done_in = 1'b1;
    await(I_RDY, 1'b1, 5);
    check(obs[I_WP], 1'b0);
    check(obs[I_P63], 1'b1);
    check(obs[I_P63OE], 1'b0);
    check(wt_oe_n, 1'b1);
    check(wt, 1'b1);
    host.drive(1'b0, 1'b0, 1'b0);
    await(I_ATTR, 1'b1, 8);
    check(obs[I_COM], 1'b0);
    hold(I_INP, 1'b1, 6);
    check(obs[I_MST], 1'b0);
    host.drive(1'b0, 1'b1, 1'b1);
    await(I_COM, 1'b1, 8);
    check(obs[I_ATTR], 1'b0);
    host.drive(1'b1, 1'b1, 1'b1);
    host.set_csel(1'b0);
    $display("test mem done");
  endtask : test_mem
  task automatic test_io;
    io_cfg_in = 1'b1;
    boot(1'b0);
    await(I_RDY, 1'b1, 30);
    host.drive(1'b0, 1'b0, 1'b0);
    await(I_INP, 1'b0, 8);
    check(buf_en, 1'b1);
    check(obs[I_WP], 1'b0);
    host.drive(1'b1, 1'b1, 1'b1);
    await(I_INP, 1'b1, 8);
    check(buf_en, 1'b0);
    addr_hit_in = 1'b0;
    host.drive(1'b0, 1'b0, 1'b0);
    hold(I_INP, 1'b1, 8);
    check(obs[I_WP], 1'b1);
    host.drive(1'b1, 1'b1, 1'b1);
    addr_hit_in = 1'b1;
    port16_in = 1'b0;
    tick(2);
    check(obs[I_WP], 1'b1);
    port16_in = 1'b1;
    tick(2);
    check(obs[I_WP], 1'b0);
    // ready change, protect change, then ready change with alerts off
    for (int i = 0; i < 3; i++) begin
      stschg_en_in = (i < 2);
      if (i == 1) wp_state_in = ~wp_state_in;
      else rdy_in = ~rdy_in;
      if (i < 2) begin
        await(I_P63, 1'b0, 3);
        hold(I_P63, 1'b0, 8);
        await(I_P63, 1'b1, 3);
      end else begin
        hold(I_P63, 1'b1, 14);
      end
    end
    $display("test io done");
  endtask : test_io
  task automatic test_reset;
    rst_pin_in = 1'b0;
    tick(8);
    rst_pin_in = 1'b1;
    await(I_RST, 1'b1, 8);
    hold(I_RST, 1'b1, 10);
    check(obs[I_RDY], 1'b0);
    rst_pin_in = 1'b0;
    await(I_RST, 1'b0, 14);
    await(I_RDY, 1'b1, 12);
    init_done_in = 1'b0;
    soft_reset_in = 1'b1;
    tick();
    soft_reset_in = 1'b0;
    await(I_RST, 1'b1, 3);
    await(I_RDY, 1'b0, 3);
    tick(3);
    init_done_in = 1'b1;
    await(I_RDY, 1'b1, 6);
    $display("test reset done");
  endtask : test_reset
  task automatic test_ide;
    for (int m = 0; m < 2; m++) begin
      host.set_csel(m == 0);
      boot(1'b1);
      await(I_RDY, 1'b1, 30);
      check(obs[I_IDE], 1'b1);
      check(obs[I_MST], m == 0);
    end
    host.drive(1'b0, 1'b0, 1'b1);
    hold(I_ATTR, 1'b0, 6);
    host.strap(1'b0);
    hold(I_IDE, 1'b1, 8);
    host.set_pd(1'b1);
    await(I_SEEN, 1'b1, 8);
    host.set_pd(1'b0);
    await(I_SEEN, 1'b0, 8);
    pdiag_assert_in = 1'b1;
    await(I_P63OE, 1'b0, 6);
    check(p63_wire, 1'b0);
    pdiag_assert_in = 1'b0;
    await(I_P63OE, 1'b1, 6);
    rst_pin_in = 1'b0;
    await(I_RST, 1'b1, 8);
    rst_pin_in = 1'b1;
    await(I_RST, 1'b0, 14);
    $display("test ide done");
  endtask : test_ide
  // main sequence
  initial begin
    test_mem();
    test_io();
    test_reset();
    test_ide();
    summarize();
  end
endmodule : testbench
